// [lxru_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module lxru_chk
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        op_valid,
  input wire logic        result_valid,
  input wire logic        condition_flag,
  input wire logic [1:0]  op_code,
  input wire logic [31:0] data_mask,
  input wire logic [39:0] state_accumulator,
  input wire logic [39:0] mask_accumulator,
  input wire logic [15:0] data_register_low_half
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire [39:0] s = state_accumulator, m = {8'h00, data_mask};
  wire c = condition_flag, r = result_valid, h = ^(s << 1 & m), d = ^(s & m);
  wire t = ^(s & mask_accumulator) ^ c;
  wire [3:0] o = {4{op_valid}} & 4'h1 << op_code;
  zero_fill_a: assert property (o[0] |=> s == $past(s) << 1) else $error("fill");
  shift_par_a: assert property (o[0] |=> c == $past(h)) else $error("p0");
  data_par_a: assert property (o[1] |=> c == $past(d)) else $error("p1");
  state_hold_a: assert property (o[1] | o[2] |=> $stable(s)) else $error("hold");
  fb_par_a: assert property (o[2] |=> c == $past(t)) else $error("p2");
  fb_shift_a: assert property (o[3] |=> s == {$past(s[38:0]), $past(t)}) else $error("p3");
  flag_keep_a: assert property (o[3] |=> $stable(c)) else $error("flag");
  low_half_a: assert property (r |-> data_register_low_half == c) else $error("low");
endmodule // lxru_chk
`default_nettype wire

// [lxru_consts.vh]
`ifndef LXRU_CONSTS_VH
`define LXRU_CONSTS_VH
`define LXRU_ACC_W        40
`define LXRU_DATA_W       32
`define LXRU_HALF_W       16
`define LXRU_OP_W         2
`define LXRU_SEL_W        3
`define LXRU_VALID_RST    1'h0
`define LXRU_DEST_RST     3'h0
`define LXRU_OP_SHIFT_D   2'h0
`define LXRU_OP_XOR_D     2'h1
`define LXRU_OP_XOR_FB    2'h2
`define LXRU_OP_SHIFT_FB  2'h3
`define LXRU_ACC_RST      40'h0000000000
`define LXRU_FLAG_RST     1'h0
`define LXRU_HALF_RST     16'h0000
`endif

// [lxru_core.sv]
`timescale 1ns/1ps
`default_nettype none
module lxru_core (
  input  wire logic         clock,
  output wire logic [127:0] word
);
  logic [31:0]  seed_reg = 32'h94ACFE98;
  logic [127:0] pool_reg = '0;
  function automatic logic [31:0] lxru_xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    lxru_xorshift = y ^ (y << 5);
  endfunction
  // decoder stand-in: a fresh random word joins the pool every rising edge
  assign word = pool_reg;
  always @(posedge clock)
  begin
    seed_reg <= lxru_xorshift(seed_reg);
    pool_reg <= #1 {pool_reg[95:0], lxru_xorshift(seed_reg)};
  end
endmodule // lxru_core
`default_nettype wire

// [lxru_unit.v]
// Contract
// RULE_01: data mask ANDs state, then parity
// RULE_02: mask accumulator ANDs state, then parity
// RULE_03: parity is XOR of all masked bits
// RULE_04: shifting form shifts state left first
// RULE_05: parity to flag and result bit zero
// RULE_06: result upper fifteen bits forced zero
// RULE_07: non-shifting data form keeps state
// RULE_08: feedback parity xor flag shifted into state
// RULE_09: shifting feedback form keeps flag
// RULE_10: feedback xor form updates flag, keeps state
// RULE_11: no other status bits touched
// RULE_12: instructions are 32-bit words
// RULE_13: may issue beside 16-bit instructions
// RULE_14: one op per cycle supports crc loop
// RULE_15: shifted state written back, zero fill
// RULE_16: data mask excludes upper eight state bits
// RULE_17: registers selected from eight data registers
`timescale 1ns/1ps
`default_nettype none
`include "lxru_consts.vh"
module lxru_unit
(
  input  wire                       clock,
  input  wire                       rst_n,
  input  wire                       op_valid,
  input  wire [`LXRU_OP_W-1:0]      op_code,
  input  wire [2:0]                 dest_sel,
  input  wire [`LXRU_DATA_W-1:0]    data_mask,
  input  wire                       state_load,
  input  wire [`LXRU_ACC_W-1:0]     state_load_value,
  input  wire                       mask_load,
  input  wire [`LXRU_ACC_W-1:0]     mask_load_value,
  input  wire                       flag_load,
  input  wire                       flag_load_value,
  output wire [`LXRU_ACC_W-1:0]     state_accumulator,
  output wire [`LXRU_ACC_W-1:0]     mask_accumulator,
  output wire                       condition_flag,
  output wire                       result_valid,
  output wire [2:0]                 result_dest,
  output wire [`LXRU_HALF_W-1:0]    data_register_low_half
);

  // chained xor of every masked bit, bit zero upward
  function parity40;
    input [`LXRU_ACC_W-1:0] v;
    integer                 i;
    reg                     p;
    begin
      p = 1'h0;
      for (i = 0; i < `LXRU_ACC_W; i = i + 1)
        p = p ^ v[i]; // RULE_03
      parity40 = p;
    end
  endfunction

  // one step left; the top state bit is lost, not saturated
  function [`LXRU_ACC_W-1:0] shift_in;
    input [`LXRU_ACC_W-1:0] v;
    input                   fill;
    begin
      shift_in = {v[`LXRU_ACC_W-2:0], fill};
    end
  endfunction

  // upper eight state bits never see a data-register mask
  function [`LXRU_ACC_W-1:0] widen_mask;
    input [`LXRU_DATA_W-1:0] d;
    begin
      widen_mask = {{(`LXRU_ACC_W-`LXRU_DATA_W){1'h0}}, d}; // RULE_16
    end
  endfunction

  function [`LXRU_HALF_W-1:0] low_half_word;
    input b;
    begin
      low_half_word = {{(`LXRU_HALF_W-1){1'h0}}, b}; // RULE_06
    end
  endfunction

  function op_is;
    input [`LXRU_OP_W-1:0] code;
    input [`LXRU_OP_W-1:0] which;
    input                  valid;
    begin
      op_is = valid && (code == which);
    end
  endfunction

  reg [`LXRU_ACC_W-1:0]  state_acc_reg;
  reg [`LXRU_ACC_W-1:0]  state_acc_next;
  reg [`LXRU_ACC_W-1:0]  mask_acc_reg;
  reg [`LXRU_ACC_W-1:0]  mask_acc_next;
  reg                    flag_reg;
  reg                    flag_next;
  reg                    valid_reg;
  reg                    valid_next;
  reg [`LXRU_SEL_W-1:0]  dest_reg;
  reg [`LXRU_SEL_W-1:0]  dest_next;
  reg [`LXRU_HALF_W-1:0] half_reg;
  reg [`LXRU_HALF_W-1:0] half_next;

  assign state_accumulator      = state_acc_reg;
  assign mask_accumulator       = mask_acc_reg;
  assign condition_flag         = flag_reg;
  assign result_valid           = valid_reg;
  assign result_dest            = dest_reg;
  assign data_register_low_half = half_reg;

  wire go_shift_d;
  wire go_xor_d;
  wire go_xor_fb;
  wire go_shift_fb;
  wire load_slot;
  wire writes_half;

  // one op word per cycle, back to back; the crc loop rotates elsewhere
  assign go_shift_d  = op_is(op_code, `LXRU_OP_SHIFT_D, op_valid); // RULE_12 RULE_13
  assign go_xor_d    = op_is(op_code, `LXRU_OP_XOR_D, op_valid); // RULE_12 RULE_13
  assign go_xor_fb   = op_is(op_code, `LXRU_OP_XOR_FB, op_valid); // RULE_12 RULE_13
  assign go_shift_fb = op_is(op_code, `LXRU_OP_SHIFT_FB, op_valid); // RULE_12 RULE_13 RULE_14
  assign load_slot   = !op_valid;
  assign writes_half = go_shift_d | go_xor_d | go_xor_fb; // RULE_05

  wire [`LXRU_ACC_W-1:0] shifted_state;
  wire [`LXRU_ACC_W-1:0] masked_shift_d;
  wire [`LXRU_ACC_W-1:0] masked_xor_d;
  wire [`LXRU_ACC_W-1:0] masked_fb;
  wire                   par_shift_d;
  wire                   par_xor_d;
  wire                   par_masked_fb;
  wire                   par_fb;

  assign shifted_state  = shift_in(state_acc_reg, 1'h0); // RULE_04 RULE_15
  assign masked_shift_d = shifted_state & widen_mask(data_mask); // RULE_01
  assign masked_xor_d   = state_acc_reg & widen_mask(data_mask); // RULE_01
  assign masked_fb      = state_acc_reg & mask_acc_reg; // RULE_02
  assign par_shift_d    = parity40(masked_shift_d);
  assign par_xor_d      = parity40(masked_xor_d);
  assign par_masked_fb  = parity40(masked_fb);
  // feedback forms fold in the flag as it stood before this op
  assign par_fb         = par_masked_fb ^ flag_reg; // RULE_08 RULE_10

  always @*
  begin
    state_acc_next = state_acc_reg;
    if (go_shift_d)
    begin
      state_acc_next = shifted_state; // RULE_15
    end
    else if (go_xor_d)
    begin
      state_acc_next = state_acc_reg; // RULE_07
    end
    else if (go_xor_fb)
    begin
      state_acc_next = state_acc_reg; // RULE_10
    end
    else if (go_shift_fb)
    begin
      state_acc_next = shift_in(state_acc_reg, par_fb); // RULE_08
    end
    else if (load_slot && state_load)
    begin
      // loads from the register file only when no op is in flight
      state_acc_next = state_load_value;
    end
  end

  always @*
  begin
    flag_next = flag_reg;
    if (go_shift_d)
    begin
      flag_next = par_shift_d; // RULE_05
    end
    else if (go_xor_d)
    begin
      flag_next = par_xor_d; // RULE_05
    end
    else if (go_xor_fb)
    begin
      flag_next = par_fb; // RULE_10
    end
    else if (go_shift_fb)
    begin
      flag_next = flag_reg; // RULE_09
    end
    else if (load_slot && flag_load)
    begin
      flag_next = flag_load_value;
    end
  end

  always @*
  begin
    mask_acc_next = mask_acc_reg;
    if (load_slot && mask_load)
    begin
      mask_acc_next = mask_load_value;
    end
  end

  always @*
  begin
    valid_next = 1'h0;
    if (writes_half)
    begin
      valid_next = 1'h1;
    end
  end

  always @*
  begin
    dest_next = dest_reg;
    if (writes_half)
    begin
      dest_next = dest_sel; // RULE_17
    end
  end

  always @*
  begin
    half_next = half_reg;
    if (writes_half)
    begin
      half_next = low_half_word(flag_next); // RULE_06
    end
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      state_acc_reg <= `LXRU_ACC_RST;
    end
    else
    begin
      state_acc_reg <= state_acc_next;
    end
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      mask_acc_reg <= `LXRU_ACC_RST;
    end
    else
    begin
      mask_acc_reg <= mask_acc_next;
    end
  end

  // the flag is the only status bit this unit drives
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      flag_reg <= `LXRU_FLAG_RST;
    end
    else
    begin
      flag_reg <= flag_next; // RULE_11
    end
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      valid_reg <= `LXRU_VALID_RST;
    end
    else
    begin
      valid_reg <= valid_next;
    end
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      dest_reg <= `LXRU_DEST_RST;
    end
    else
    begin
      dest_reg <= dest_next;
    end
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      half_reg <= `LXRU_HALF_RST;
    end
    else
    begin
      half_reg <= half_next;
    end
  end

endmodule // lxru_unit
`default_nettype wire

// [lxru_unit_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module lxru_unit_bench;
  logic clock = 0, rst_n = 0, f, v, l;
  logic [39:0] s, m;
  logic [2:0] d;
  wire [127:0] w;
  wire [100:0] q;
  // parity the rules give for the op on the pins this cycle
  wire p = w[2] ? ^(s & m) ^ f : ^((w[1] ? s : s << 1) & w[37:6]);
  int bad_count = 0, checks_done = 0, n = 0;
  always #2.5 clock = ~clock;
  initial #8.5 rst_n = 1;
  lxru_core core (.clock(clock), .word(w));
  lxru_unit uut (.clock(clock), .rst_n(rst_n), .op_valid(w[0]), .op_code(w[2:1]),
    .dest_sel(w[5:3]), .data_mask(w[37:6]), .state_load(w[38]), .state_load_value(w[78:39]),
    .mask_load(w[79]), .mask_load_value(w[119:80]), .flag_load(w[120]),
    .flag_load_value(w[121]), .state_accumulator(q[100:61]), .mask_accumulator(q[60:21]),
    .condition_flag(q[20]), .result_valid(q[19]), .result_dest(q[18:16]),
    .data_register_low_half(q[15:0]));
  task check(input logic [100:0] a, e);
    checks_done++;
    bad_count += a !== e;
    if (a !== e) $display("ERROR %0t %h %h", $time, a, e);
  endtask
  task close_out;
    $display("%0d %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock)
  begin
    if (rst_n) check(q[100:0], {s, m, f, v, d, 15'h0, l});
    v <= w[0] && w[2:1] != 2'h3;
    if (w[0] && w[2:1] != 2'h3) {f, d, l} <= {p, w[5:3], p};
    if (w[0]) s <= w[2:1] == 2'h0 ? s << 1 : w[2:1] == 2'h3 ? {s[38:0], p} : s;
    else if (w[38]) s <= w[78:39];
    if (!w[0] && w[79]) m <= w[119:80];
    if (!w[0] && w[120]) f <= w[121];
    if (!rst_n) {s, m, f, v, d, l} <= '0;
    if (checks_done == 1000) close_out;
    else if (++n == 2000)
    begin
      bad_count++;
      close_out;
    end
  end
endmodule // lxru_unit_bench
bind lxru_unit lxru_chk chk (.*);
`default_nettype wire
